// *** src/independent_window_watchdog.sv ***
// Independent window watchdog with an AXI4-Lite register port.
// Assumes the option word and mode strap are stable around reset release,
// and that watchdog_count_clock is a slow clock sampled as a plain input.
// Notes on behaviour
// - Reset stops counter, restores all registers
// - Low power stops counting if stop bit 1
// - Register-start mode halts after underflow or error
// - Window start and end positions configurable
// - Underflow or out-of-window refresh raises output
// - Counter value readable through status register
// - Auto-start mode uses option word settings
// - Register-start mode uses control registers
// - Counter driven by dedicated watchdog clock
// - Write 00h then FFh is one refresh
// - Auto-start refresh reloads option timeout value
// - Register-start begins at first refresh
// - Refresh register reads 00h or FFh
// - Auto-start runs at reset release
// - Divide by 1,16,32,64,128 or 256
// - Timeout 128, 512, 1024 or 2048 cycles
// - End beyond start: only start honoured
//
// The AXI4-Lite slave port is this design's own decision.
`include "watchdog_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module independent_window_watchdog #(
	parameter int ADDR_W = 32
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic watchdog_count_clock,
	input wire logic auto_start_mode,
	input wire watchdog_pkg::opt_word_t option_word_zero,
	input wire logic low_power_entry,
	output logic wdt_reset_req,
	output logic wdt_nmi_req,
	output logic sleep_stop_ctl,
	output logic irq
);
	// Bus channel state
	logic aw_have_r, w_have_r;
	logic [ADDR_W-1:0] aw_addr_r;
	logic [31:0] wdata_r;
	logic [3:0] wstrb_r;
	logic bvalid_r, rvalid_r;
	logic [1:0] bresp_r, rresp_r;
	logic [31:0] rdata_r;
	// Registers
	logic auto_r;
	watchdog_pkg::opt_word_t opt_r;
	watchdog_pkg::wd_ctrl_t ctrl_r;
	logic rst_irq_r, cstop_r;
	logic [7:0] refresh_r;
	logic armed_r;
	logic [1:0] evt_stat_r, evt_en_r;
	// Counting state
	logic running_r, halted_r, started_r;
	logic [13:0] cnt_r;
	logic [7:0] pre_r;
	logic wclk_prev_r;
	logic rst_out_r, nmi_out_r;

	// Prescaler terminal count for a divide code
	function automatic logic [7:0] div_last(input logic [3:0] sel);
		case (sel)
			`DIV_16: div_last = 8'h0F;
			`DIV_32: div_last = 8'h1F;
			`DIV_64: div_last = 8'h3F;
			`DIV_128: div_last = 8'h7F;
			`DIV_256: div_last = 8'hFF;
			default: div_last = 8'h00;
		endcase
	endfunction

	// Reload value for a timeout code
	function automatic logic [13:0] top_val(input logic [1:0] sel);
		case (sel)
			2'h0: top_val = 14'h007F;
			2'h1: top_val = 14'h01FF;
			2'h2: top_val = 14'h03FF;
			default: top_val = 14'h07FF;
		endcase
	endfunction

	// Counter value at a given number of quarters of the period
	function automatic logic [14:0] quarter_pos(input logic [1:0] tsel, input logic [2:0] q);
		logic [16:0] per;
		per = {3'h0, top_val(tsel)} + 17'h1;
		quarter_pos = 15'((per * 17'(q)) >> 2) - 15'h1;
	endfunction

	// Write byte-lane merge
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
			input logic [3:0] strb);
		for (int i = 0; i < 4; i++) begin
			merge[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
		end
	endfunction

	// Active settings: option word or registers by mode
	watchdog_pkg::wd_ctrl_t cfg;
	logic sel_reset, sel_sleep_stop;
	assign cfg = auto_r ? opt_r.cfg : ctrl_r;
	assign sel_reset = auto_r ? opt_r.opt_reset_or_irq_select : rst_irq_r;
	assign sel_sleep_stop = auto_r ? opt_r.opt_sleep_count_stop : cstop_r;

	// Window bounds, start and end as counter values
	wire [2:0] start_q = 3'(cfg.window_start_select) + 3'h1;
	wire [2:0] end_q = 3'h3 - 3'(cfg.window_end_select);
	wire [14:0] start_v = quarter_pos(cfg.timeout_select, start_q);
	wire [14:0] end_v = quarter_pos(cfg.timeout_select, end_q);
	wire end_used = (end_q != 3'h0) && (end_q < start_q);
	wire in_window = ({1'b0, cnt_r} <= start_v) && (!end_used || ({1'b0, cnt_r} > end_v));

	// Count clock edge and divided tick
	wire wclk_rise = watchdog_count_clock && !wclk_prev_r;
	wire lp_stop = low_power_entry && sel_sleep_stop;
	wire counting = running_r && !lp_stop;
	wire pre_done = (pre_r >= div_last(cfg.clock_divide_select));
	wire cnt_tick = counting && wclk_rise && pre_done;
	wire underflow = cnt_tick && (cnt_r == 14'h0000);

	// Bus decode
	wire do_write = aw_have_r && w_have_r && !bvalid_r;
	wire do_read = s_axi_arvalid && !rvalid_r;
	wire [31:0] waddr = 32'(aw_addr_r);
	wire [31:0] raddr = 32'(s_axi_araddr);
	wire hit_wr_refresh = do_write && (waddr == `ADDR_REFRESH) && wstrb_r[0];
	wire hit_wr_ctrl = do_write && (waddr == `ADDR_CONTROL);
	wire hit_wr_rstc = do_write && (waddr == `ADDR_RST_CTRL) && wstrb_r[0];
	wire hit_wr_cstop = do_write && (waddr == `ADDR_CSTOP) && wstrb_r[0];
	wire hit_wr_clr = do_write && (waddr == `ADDR_EVT_CLR) && wstrb_r[0];
	wire hit_wr_en = do_write && (waddr == `ADDR_EVT_EN) && wstrb_r[0];
	wire wr_mapped = (waddr == `ADDR_REFRESH) || (waddr == `ADDR_CONTROL) ||
		(waddr == `ADDR_STATUS) || (waddr == `ADDR_RST_CTRL) || (waddr == `ADDR_CSTOP) ||
		(waddr == `ADDR_EVT_STAT) || (waddr == `ADDR_EVT_CLR) || (waddr == `ADDR_EVT_EN);
	wire [7:0] wbyte = wdata_r[7:0];

	// Refresh sequence decode
	wire wr_first = hit_wr_refresh && (wbyte == `REFRESH_FIRST);
	wire refresh_op = hit_wr_refresh && armed_r && (wbyte == `REFRESH_SECOND);
	wire refresh_ok = refresh_op && (!running_r || in_window);
	wire refresh_err = refresh_op && running_r && !in_window;
	wire [1:0] evt_set = {refresh_err, underflow};
	watchdog_pkg::wd_event_t evt_kind;
	assign evt_kind = underflow ? watchdog_pkg::EV_UNDERFLOW :
		(refresh_err ? watchdog_pkg::EV_REFRESH_ERR : watchdog_pkg::EV_NONE);
	wire evt_any = (evt_kind != watchdog_pkg::EV_NONE);
	wire start_ok = refresh_ok && !auto_r && !running_r && !halted_r;

	// Read data mux
	logic [31:0] rd_mux;
	logic rd_mapped;
	always_comb begin
		rd_mapped = 1'b1;
		case (raddr)
			`ADDR_REFRESH: rd_mux = {24'h0, refresh_r};
			`ADDR_CONTROL: rd_mux = {16'h0, ctrl_r};
			`ADDR_STATUS: rd_mux = {18'h0, cnt_r};
			`ADDR_RST_CTRL: rd_mux = {31'h0, rst_irq_r};
			`ADDR_CSTOP: rd_mux = {31'h0, cstop_r};
			`ADDR_EVT_STAT: rd_mux = {30'h0, evt_stat_r};
			`ADDR_EVT_CLR: rd_mux = 32'h0000_0000;
			`ADDR_EVT_EN: rd_mux = {30'h0, evt_en_r};
			default: begin
				rd_mux = 32'h0000_0000;
				rd_mapped = 1'b0;
			end
		endcase
	end

	// Handshake outputs
	assign s_axi_awready = !aw_have_r;
	assign s_axi_wready = !w_have_r;
	assign s_axi_arready = !rvalid_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rresp = rresp_r;
	assign s_axi_rdata = rdata_r;
	assign wdt_reset_req = rst_out_r;
	assign wdt_nmi_req = nmi_out_r;
	assign sleep_stop_ctl = sel_sleep_stop;
	assign irq = |(evt_stat_r & evt_en_r);

	// Write channel capture and response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_r <= 1'b0;
			w_have_r <= 1'b0;
			aw_addr_r <= '0;
			wdata_r <= 32'h0000_0000;
			wstrb_r <= 4'h0;
			bvalid_r <= 1'b0;
			bresp_r <= `RESP_OKAY;
		end else begin
			if (s_axi_awvalid && !aw_have_r) begin
				aw_have_r <= 1'b1;
				aw_addr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && !w_have_r) begin
				w_have_r <= 1'b1;
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
			end
			if (do_write) begin
				bvalid_r <= 1'b1;
				bresp_r <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
			end else if (bvalid_r && s_axi_bready) begin
				bvalid_r <= 1'b0;
				aw_have_r <= 1'b0;
				w_have_r <= 1'b0;
			end
		end
	end

	// Read channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_r <= 1'b0;
			rdata_r <= 32'h0000_0000;
			rresp_r <= `RESP_OKAY;
		end else if (do_read) begin
			rvalid_r <= 1'b1;
			rdata_r <= rd_mux;
			rresp_r <= rd_mapped ? `RESP_OKAY : `RESP_SLVERR;
		end else if (s_axi_rready) begin
			rvalid_r <= 1'b0;
		end
	end

	// Software registers; option word and strap caught during reset
	logic [31:0] ctrl_nxt;
	assign ctrl_nxt = merge({16'h0, ctrl_r}, wdata_r, wstrb_r) & {16'h0, `CTRL_MASK};
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			auto_r <= auto_start_mode;
			opt_r <= option_word_zero;
			ctrl_r <= `CTRL_RST;
			rst_irq_r <= 1'b0;
			cstop_r <= 1'b0;
			evt_en_r <= 2'b00;
		end else begin
			if (hit_wr_ctrl && !running_r && !started_r) begin
				ctrl_r <= watchdog_pkg::wd_ctrl_t'(ctrl_nxt[15:0]);
			end
			if (hit_wr_rstc) begin
				rst_irq_r <= wdata_r[0];
			end
			if (hit_wr_cstop) begin
				cstop_r <= wdata_r[0];
			end
			if (hit_wr_en) begin
				evt_en_r <= wdata_r[1:0];
			end
		end
	end

	// Refresh register readback and sequence tracking
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			refresh_r <= `REFRESH_RST;
			armed_r <= 1'b0;
		end else if (hit_wr_refresh) begin
			refresh_r <= (wbyte == `REFRESH_FIRST) ? `REFRESH_FIRST : `REFRESH_SECOND;
			armed_r <= wr_first;
		end
	end

	// Sticky event flags; a new event beats a clear in the same cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			evt_stat_r <= 2'b00;
		end else begin
			evt_stat_r <= (evt_stat_r & ~(hit_wr_clr ? wdata_r[1:0] : 2'b00)) | evt_set;
		end
	end

	// Reset or interrupt request pulse
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rst_out_r <= 1'b0;
			nmi_out_r <= 1'b0;
		end else begin
			rst_out_r <= evt_any && sel_reset;
			nmi_out_r <= evt_any && !sel_reset;
		end
	end

	// Prescaler on the watchdog clock edges
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wclk_prev_r <= watchdog_count_clock; // No false edge at release
			pre_r <= 8'h00;
		end else begin
			wclk_prev_r <= watchdog_count_clock;
			if (refresh_ok || !counting) begin
				pre_r <= 8'h00;
			end else if (wclk_rise) begin
				pre_r <= pre_done ? 8'h00 : pre_r + 8'h01;
			end
		end
	end

	// Down-counter and run state
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			running_r <= auto_start_mode;
			halted_r <= 1'b0;
			cnt_r <= auto_start_mode ? top_val(option_word_zero.cfg.timeout_select) : `CNT_IDLE;
		end else if (evt_any && !auto_r) begin
			running_r <= 1'b0;
			halted_r <= 1'b1;
		end else if (refresh_ok && !halted_r) begin
			running_r <= 1'b1;
			cnt_r <= top_val(cfg.timeout_select);
		end else if (underflow) begin
			cnt_r <= top_val(cfg.timeout_select);
		end else if (cnt_tick) begin
			cnt_r <= cnt_r - 14'h0001;
		end
	end

	// Start event of the register-start path; locks the control register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			started_r <= 1'b0;
		end else if (start_ok) begin
			started_r <= 1'b1;
		end
	end
endmodule // independent_window_watchdog
`default_nettype wire

// *** include/watchdog_consts.svh ***
// Constants for the independent window watchdog: register byte addresses,
// field positions, reset values and bus answers.
// Assumes 32-bit AXI4-Lite data, one register to an aligned word.
`ifndef WATCHDOG_CONSTS_SVH
`define WATCHDOG_CONSTS_SVH
`define ADDR_REFRESH 32'h0008_8030
`define ADDR_CONTROL 32'h0008_8034
`define ADDR_STATUS 32'h0008_8038
`define ADDR_RST_CTRL 32'h0008_803C
`define ADDR_CSTOP 32'h0008_8040
`define ADDR_EVT_STAT 32'h0008_8044
`define ADDR_EVT_CLR 32'h0008_8048
`define ADDR_EVT_EN 32'h0008_804C
`define CTRL_RST 16'h33F3
`define CTRL_MASK 16'h33F3
`define REFRESH_RST 8'hFF
`define REFRESH_FIRST 8'h00
`define REFRESH_SECOND 8'hFF
`define CNT_IDLE 14'h3FFF
`define DIV_1 4'h0
`define DIV_16 4'h2
`define DIV_32 4'h3
`define DIV_64 4'h4
`define DIV_128 4'hF
`define DIV_256 4'h5
`define EVT_UNDERFLOW 0
`define EVT_REFRESH_ERR 1
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// *** include/watchdog_pkg.sv ***
// Types for the independent window watchdog.
// Assumes nothing beyond a SystemVerilog compiler.
package watchdog_pkg;
	// Option word and control register share this layout
	typedef struct packed {
		logic [1:0] rsvd_hi;
		logic [1:0] window_start_select;
		logic [1:0] rsvd_mid;
		logic [1:0] window_end_select;
		logic [3:0] clock_divide_select;
		logic [1:0] rsvd_lo;
		logic [1:0] timeout_select;
	} wd_ctrl_t;
	// Full non-volatile option word
	typedef struct packed {
		logic opt_sleep_count_stop;
		logic opt_reset_or_irq_select;
		wd_ctrl_t cfg;
	} opt_word_t;
	typedef enum logic [1:0] {
		EV_NONE = 2'b00,
		EV_UNDERFLOW = 2'b01,
		EV_REFRESH_ERR = 2'b10
	} wd_event_t;
endpackage

// *** dv/independent_window_watchdog_chk.sv ***
// Concurrent checks on the watchdog's top ports.
// Assumes one clock, aclk, and a synchronous active-low aresetn.
`timescale 1ns/1ps
`default_nettype none
module independent_window_watchdog_chk (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic wdt_reset_req,
	input wire logic wdt_nmi_req,
	input wire logic irq
);
	// One domain for every check
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// Reset leaves bus and outputs quiet
	a_reset_quiet: assert property (
		$rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid && !irq)
		else $error("bus or irq busy at reset release");
	a_no_early_event: assert property (
		$rose(aresetn) |-> (!wdt_reset_req && !wdt_nmi_req) [*8])
		else $error("event output right after reset");
	// Event outputs are single pulses
	a_pulse_single: assert property (
		wdt_reset_req || wdt_nmi_req |=> !wdt_reset_req && !wdt_nmi_req)
		else $error("event output longer than one cycle");
	a_irq_cause: assert property (
		$rose(irq) |-> s_axi_bvalid || $past(s_axi_wvalid) || wdt_reset_req || wdt_nmi_req)
		else $error("irq rose without event or write");
	// Register port answers
	a_read_answer: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_read_hold: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped before accepted");
	a_read_block: assert property (
		s_axi_rvalid |-> !s_axi_arready)
		else $error("address taken while read pending");
	// Both halves held one cycle, response registered the next
	a_write_answer: assert property (
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("write answer late");
	a_write_block: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready)
		else $error("write response dropped or bus reopened");
endmodule // independent_window_watchdog_chk
bind independent_window_watchdog independent_window_watchdog_chk chk_u (.aclk, .aresetn,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
	.wdt_reset_req, .wdt_nmi_req, .irq);
`default_nettype wire

// *** dv/tb_independent_window_watchdog.sv ***
// Self-checking bench for the independent window watchdog.
// Assumes the package and design compile first and the include path holds the constants.
`include "watchdog_consts.svh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin fails++; \
	$display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module tb_independent_window_watchdog;
	logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic watchdog_count_clock, auto_start_mode, low_power_entry, sleep_stop_ctl, irq;
	logic wdt_reset_req, wdt_nmi_req, got_rst, got_nmi;
	logic [31:0] s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_rdata, rd_v, keep_v, seed;
	logic [1:0] s_axi_bresp, s_axi_rresp, rd_r, wr_b;
	logic [7:0] v;
	watchdog_pkg::opt_word_t option_word_zero;
	int fails, tests_run, m_rr;
	independent_window_watchdog dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0),
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .watchdog_count_clock, .auto_start_mode,
		.option_word_zero, .low_power_entry, .wdt_reset_req, .wdt_nmi_req, .sleep_stop_ctl, .irq);
	// Bus clock, 4 ns
	initial begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end
	// Raw watchdog ticks, one every eight bus clocks
	always begin
		repeat (4) @(posedge aclk);
		watchdog_count_clock <= ~watchdog_count_clock;
	end
	// Sticky record of event pulses
	always @(negedge aclk) begin
		got_rst = got_rst | wdt_reset_req;
		got_nmi = got_nmi | wdt_nmi_req;
	end
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	task automatic do_reset(input logic mode, input logic [17:0] opt);
		@(posedge aclk);
		aresetn <= 1'b0;
		auto_start_mode <= mode;
		option_word_zero <= opt;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
	endtask
	// Write: address and data offered together, held until each is taken
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [2:0] busy;
		logic [2:0] seen;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		busy = 3'h7;
		while (busy != 3'h0) begin
			@(negedge aclk);
			seen = busy & {s_axi_awready, s_axi_wready, s_axi_bvalid};
			wr_b = s_axi_bresp;
			@(posedge aclk);
			busy = busy & ~seen;
			{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= busy;
		end
	endtask
	task automatic rd(input logic [31:0] a);
		logic [1:0] busy;
		logic [1:0] seen;
		@(posedge aclk);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		busy = 2'h3;
		while (busy != 2'h0) begin
			@(negedge aclk);
			seen = busy & {s_axi_arready, s_axi_rvalid};
			rd_v = s_axi_rdata;
			rd_r = s_axi_rresp;
			@(posedge aclk);
			busy = busy & ~seen;
			{s_axi_arvalid, s_axi_rready} <= busy;
		end
	endtask
	task automatic wait_event;
		for (int i = 0; i < 3000 && !(got_rst | got_nmi); i++) @(posedge aclk);
	endtask
	task automatic refresh;
		wr(`ADDR_REFRESH, 32'h00);
		wr(`ADDR_REFRESH, 32'hFF);
	endtask
	task automatic conclude;
		$display("checks %0d, mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// Hang guard
	initial begin
		repeat (20000) @(posedge aclk);
		fails++;
		conclude();
	end
	// Main sequence
	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, low_power_entry, watchdog_count_clock} = '0;
		{auto_start_mode, option_word_zero, got_rst, got_nmi} = '0;
		seed = 32'h4C;
		do_reset(1'b0, 18'h00000);
		rd(`ADDR_REFRESH);
		`CHK("refresh reset", 32'hFF, rd_v)
		rd(`ADDR_CONTROL);
		`CHK("control reset", 32'h33F3, rd_v)
		rd(`ADDR_STATUS);
		`CHK("status reset", 32'h3FFF, rd_v)
		rd(32'h0008_8050);
		`CHK("unmapped resp", `RESP_SLVERR, rd_r)
		wr(32'h0008_8050, 32'h0);
		`CHK("unmapped write resp", `RESP_SLVERR, wr_b)
		$display("test reset_values done");
		repeat (4) begin
			seed = xs(seed);
			v = seed[7:0] & {8{seed[8]}};
			m_rr = (v == 8'h00) ? 0 : 255;
			wr(`ADDR_REFRESH, {24'h0, v});
			rd(`ADDR_REFRESH);
			`CHK("refresh readback", m_rr, rd_v)
		end
		wr(`ADDR_REFRESH, {24'h0, seed[15:8] | 8'h01});
		wr(`ADDR_REFRESH, 32'hFF);
		rd(`ADDR_STATUS);
		`CHK("status after bad pair", 32'h3FFF, rd_v)
		$display("test refresh_order done");
		wr(`ADDR_CONTROL, 32'h3300);
		`CHK("control write resp", `RESP_OKAY, wr_b)
		wr(`ADDR_RST_CTRL, 32'h0);
		wr(`ADDR_CSTOP, 32'h1);
		rd(`ADDR_CONTROL);
		`CHK("control written", 32'h3300, rd_v)
		`CHK("sleep stop out", 1'b1, sleep_stop_ctl)
		refresh();
		rd(`ADDR_STATUS);
		`CHK("started at timeout", 1'b1, rd_v == 32'h7F || rd_v == 32'h7E)
		wr(`ADDR_CONTROL, 32'h0);
		rd(`ADDR_CONTROL);
		`CHK("control locked", 32'h3300, rd_v)
		low_power_entry <= 1'b1;
		rd(`ADDR_STATUS);
		keep_v = rd_v;
		repeat (40) @(posedge aclk);
		rd(`ADDR_STATUS);
		`CHK("count held in low power", keep_v, rd_v)
		low_power_entry <= 1'b0;
		wait_event();
		`CHK("nmi on underflow", 2'b01, {got_rst, got_nmi})
		rd(`ADDR_EVT_STAT);
		`CHK("underflow status", 32'h1, rd_v)
		`CHK("irq masked", 1'b0, irq)
		rd(`ADDR_STATUS);
		keep_v = rd_v;
		repeat (40) @(posedge aclk);
		rd(`ADDR_STATUS);
		`CHK("halted after underflow", keep_v, rd_v)
		wr(`ADDR_EVT_EN, 32'h3);
		@(negedge aclk);
		`CHK("irq enabled", 1'b1, irq)
		wr(`ADDR_EVT_CLR, 32'h1);
		rd(`ADDR_EVT_STAT);
		`CHK("status cleared", 32'h0, rd_v)
		`CHK("irq cleared", 1'b0, irq)
		$display("test register_mode done");
		// Window start at 50%, end at 75%: end lies beyond start, so only start counts
		do_reset(1'b1, 18'h11000);
		{got_rst, got_nmi} = 2'b00;
		wr(`ADDR_CSTOP, 32'h1);
		`CHK("option sleep stop", 1'b0, sleep_stop_ctl)
		rd(`ADDR_STATUS);
		`CHK("auto running", 1'b1, rd_v == 32'h7F || rd_v == 32'h7E)
		refresh();
		wait_event();
		`CHK("reset on early refresh", 2'b10, {got_rst, got_nmi})
		rd(`ADDR_EVT_STAT);
		`CHK("error status", 32'h2, rd_v)
		wr(`ADDR_EVT_CLR, 32'h3);
		do rd(`ADDR_STATUS); while (rd_v > 32'h1E);
		{got_rst, got_nmi} = 2'b00;
		refresh();
		rd(`ADDR_STATUS);
		`CHK("auto reload", 1'b1, rd_v == 32'h7F || rd_v == 32'h7E)
		`CHK("start only window", 2'b00, {got_rst, got_nmi})
		rd(`ADDR_EVT_STAT);
		`CHK("no error in window", 32'h0, rd_v)
		$display("test auto_mode done");
		// Register start, divide by 16, 512-cycle period, window 75% to 50%
		do_reset(1'b0, 18'h00000);
		{got_rst, got_nmi} = 2'b00;
		wr(`ADDR_CONTROL, 32'h2121);
		wr(`ADDR_RST_CTRL, 32'h1);
		refresh();
		rd(`ADDR_STATUS);
		`CHK("timeout 512 reload", 32'h1FF, rd_v)
		repeat (90) @(posedge aclk);
		rd(`ADDR_STATUS);
		`CHK("divided count held", 32'h1FF, rd_v)
		refresh();
		`CHK("reset on refresh error", 2'b10, {got_rst, got_nmi})
		rd(`ADDR_STATUS);
		keep_v = rd_v;
		repeat (300) @(posedge aclk);
		rd(`ADDR_STATUS);
		`CHK("halted after error", keep_v, rd_v)
		$display("test divided_mode done");
		conclude();
	end
endmodule // tb_independent_window_watchdog
`default_nettype wire
